// *** hdl/cmac_map.vh ***
`ifndef CMAC_MAP_VH
`define CMAC_MAP_VH
// Function
// - Fixed priority channel one, two, three, arithmetic unit
// - Arithmetic unit request held in fourth flip-flop
// - Request sets when alone or at cycle end
// - Grant is request and no higher request
// - Grant starts cycle and hands over paths
// - Priority resolved on third clock after request, behind two sync flops
// - Grant signals requester, enables counter and selects
// - Route winner address, data and read/write
// - Read or write request; read enables parity check
// - Four-stage counter advances every clock in cycle
// - Counter halts on stop parity or temperature alarm
// - Initiate from grant until count two
// - Address bit 14 picks the initiated stack
// - Data ready at count eight
// - Cycle complete at count fifteen
// - Release to arithmetic unit at completion
// - Cycle start needs initiate, not busy, power good
// - Cycle start launches timing and sets busy
// - Address strobe loads bit and word address
// - Bits 12 and 13 pick one sense enable
// - Strobe loads sensed or write data
// - Bit drives only for data ones
// - Read data checked for odd parity
`define CMAC_NREQ 4
`define CMAC_AW 15
`define CMAC_DW 24
`define CMAC_CNT_INIT_OFF 4'h2
`define CMAC_CNT_READY 4'h8
`define CMAC_CNT_DONE 4'hF
`define CMAC_MOD_STROBE 4'h3
`define CMAC_MOD_WRITE 4'h5
`define CMAC_MOD_END 4'hC
`define CMAC_STACK_BIT 14
`define CMAC_BANK_BIT 13
`define CMAC_PLANE_BIT 12
`endif

// *** hdl/cmac_arbiter.v ***
`include "cmac_map.vh"
module cmac_arbiter (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] req_in,
  input wire cycle_last,
  input wire busy,
  output reg [3:0] req_ff,
  output wire [3:0] grant
);
  integer i;
  reg [3:0] next_req_ff;
  always @* begin
    next_req_ff = req_ff;
    for (i = 0; i < `CMAC_NREQ; i = i + 1) begin
      // Latch when no other request is pending, or at the last clock of a cycle
      if (req_in[i] && (req_ff == 4'h0 || cycle_last)) begin
        next_req_ff[i] = 1'b1;
      end
    end
    if (cycle_last) begin
      next_req_ff = next_req_ff & ~grant;
    end
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= 4'h0;
    end else begin
      req_ff <= next_req_ff;
    end
  end
  // Index 0 is channel one, index 3 the arithmetic unit
  assign grant[0] = req_ff[0];
  assign grant[1] = req_ff[1] & ~req_ff[0];
  assign grant[2] = req_ff[2] & ~req_ff[1] & ~req_ff[0];
  assign grant[3] = req_ff[3] & ~req_ff[2] & ~req_ff[1] & ~req_ff[0];
  wire unused_busy = busy;
endmodule // cmac_arbiter

// *** hdl/cmac_module.v ***
`include "cmac_map.vh"
module cmac_module (
  input wire core_clk,
  input wire rst_n,
  input wire initiate,
  input wire power_fail,
  input wire write_mode,
  input wire [13:0] addr,
  input wire [23:0] write_data,
  input wire [23:0] sense_data,
  output reg cycle_start_ff,
  output reg module_busy_ff,
  output reg [3:0] bit_addr_reg,
  output reg [8:0] lower_word_addr,
  output reg [8:0] upper_word_addr,
  output reg [3:0] plane_sense_enable,
  output reg [23:0] data_reg,
  output reg data_reg_strobe,
  output reg [23:0] bit_switch_enable
);
  reg [3:0] phase;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_start_ff <= 1'b0;
      module_busy_ff <= 1'b0;
      phase <= 4'h0;
      bit_addr_reg <= 4'h0;
      lower_word_addr <= 9'h000;
      upper_word_addr <= 9'h000;
      plane_sense_enable <= 4'h0;
      data_reg <= 24'h000000;
      data_reg_strobe <= 1'b0;
      bit_switch_enable <= 24'h000000;
    end else begin
      cycle_start_ff <= initiate && !module_busy_ff && !cycle_start_ff && !power_fail;
      data_reg_strobe <= 1'b0;
      if (cycle_start_ff) begin
        module_busy_ff <= 1'b1;
        phase <= 4'h1;
        bit_addr_reg <= addr[3:0];
        if (!addr[`CMAC_BANK_BIT]) lower_word_addr <= addr[12:4];
        else upper_word_addr <= addr[12:4];
        plane_sense_enable <= 4'h1 << addr[13:12];
      end else if (module_busy_ff) begin
        phase <= phase + 4'h1;
        if (phase == `CMAC_MOD_STROBE) begin
          data_reg <= write_mode ? write_data : sense_data;
          data_reg_strobe <= 1'b1;
          plane_sense_enable <= 4'h0;
        end
        if (phase == `CMAC_MOD_WRITE) begin
          bit_switch_enable <= data_reg;
        end
        if (phase == `CMAC_MOD_END) begin
          bit_switch_enable <= 24'h000000;
          module_busy_ff <= 1'b0;
          phase <= 4'h0;
        end
      end
    end
  end
endmodule // cmac_module

// *** hdl/cmac_top.v ***
`include "cmac_map.vh"
module cmac_top (
  input wire core_clk,
  input wire rst_n,
  input wire [2:0] ch_mem_request,
  input wire au_mem_request,
  input wire [3:0] req_write,
  input wire [59:0] req_addr,
  input wire [95:0] req_wdata,
  input wire [23:0] sense_data,
  input wire sense_parity,
  input wire stop_on_parity,
  input wire temp_alarm,
  input wire power_fail,
  input wire large_system,
  output reg [3:0] access_granted,
  output reg [3:0] data_ready,
  output reg au_release,
  output reg time_counter_enable,
  output reg [3:0] cycle_time_counter,
  output reg [3:0] addr_mux_select,
  output reg [3:0] data_mux_select,
  output reg [14:0] addr_mux_bit,
  output reg [23:0] data_mux_bit,
  output reg read_request_gate,
  output reg write_request_gate,
  output reg parity_check_enable,
  output reg module_initiate,
  output reg lower_stack_initiate,
  output reg upper_stack_initiate,
  output reg parity_error,
  output reg [23:0] read_data,
  output reg cycle_start,
  output reg module_busy,
  output reg [3:0] bit_addr,
  output reg [3:0] plane_sense_enable,
  output reg [23:0] bit_switch_enable
);
  // Request, alarm and power-fail pins pass two flops first
  reg [3:0] req_s1, req_s2;
  reg [1:0] alarm_s1, alarm_s2;
  reg pf_s1, pf_s2;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1 <= 4'h0;
      req_s2 <= 4'h0;
      alarm_s1 <= 2'h0;
      alarm_s2 <= 2'h0;
      pf_s1 <= 1'b0;
      pf_s2 <= 1'b0;
    end else begin
      req_s1 <= {au_mem_request, ch_mem_request};
      req_s2 <= req_s1;
      alarm_s1 <= {temp_alarm, stop_on_parity};
      alarm_s2 <= alarm_s1;
      pf_s1 <= power_fail;
      pf_s2 <= pf_s1;
    end
  end

  reg active;
  wire cycle_last = active && (cycle_time_counter == `CMAC_CNT_DONE);
  wire [3:0] req_ff;
  wire [3:0] grant;
  cmac_arbiter u_arb (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .req_in(req_s2),
    .cycle_last(cycle_last),
    .busy(active),
    .req_ff(req_ff),
    .grant(grant)
  );

  // Selected requester's fields
  reg [14:0] sel_addr;
  reg [23:0] sel_data;
  reg sel_write;
  integer k;
  always @* begin
    sel_addr = 15'h0000;
    sel_data = 24'h000000;
    sel_write = 1'b0;
    for (k = 0; k < `CMAC_NREQ; k = k + 1) begin
      if (grant[k]) begin
        sel_addr = req_addr[k*15 +: 15];
        sel_data = req_wdata[k*24 +: 24];
        sel_write = req_write[k];
      end
    end
  end

  // Parity: 24 data bits plus parity bit must be odd
  wire stall = (parity_error && alarm_s2[0]) || alarm_s2[1];
  wire mod_strobe;
  wire [23:0] mod_data;
  wire mod_start, mod_busy;
  wire [3:0] mod_bit_addr, mod_sense;
  wire [23:0] mod_bits;
  wire mod_initiate = module_initiate || lower_stack_initiate || upper_stack_initiate;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      cycle_time_counter <= 4'h0;
      access_granted <= 4'h0;
      data_ready <= 4'h0;
      au_release <= 1'b0;
      time_counter_enable <= 1'b0;
      addr_mux_select <= 4'h0;
      data_mux_select <= 4'h0;
      addr_mux_bit <= 15'h0000;
      data_mux_bit <= 24'h000000;
      read_request_gate <= 1'b0;
      write_request_gate <= 1'b0;
      parity_check_enable <= 1'b0;
      module_initiate <= 1'b0;
      lower_stack_initiate <= 1'b0;
      upper_stack_initiate <= 1'b0;
      parity_error <= 1'b0;
      read_data <= 24'h000000;
    end else begin
      data_ready <= 4'h0;
      au_release <= 1'b0;
      if (!active && grant != 4'h0) begin
        active <= 1'b1;
        cycle_time_counter <= 4'h0;
        access_granted <= grant;
        time_counter_enable <= 1'b1;
        addr_mux_select <= grant;
        data_mux_select <= grant;
        addr_mux_bit <= sel_addr;
        data_mux_bit <= sel_data;
        read_request_gate <= !sel_write;
        write_request_gate <= sel_write;
        parity_check_enable <= !sel_write;
        parity_error <= 1'b0;
        module_initiate <= !large_system;
        lower_stack_initiate <= large_system && !sel_addr[`CMAC_STACK_BIT];
        upper_stack_initiate <= large_system && sel_addr[`CMAC_STACK_BIT];
      end else if (active) begin
        if (!stall) begin
          cycle_time_counter <= cycle_time_counter + 4'h1;
        end
        time_counter_enable <= !stall;
        if (!stall && cycle_time_counter + 4'h1 == `CMAC_CNT_INIT_OFF) begin
          module_initiate <= 1'b0;
          lower_stack_initiate <= 1'b0;
          upper_stack_initiate <= 1'b0;
        end
        if (mod_strobe && parity_check_enable) begin
          read_data <= mod_data;
          parity_error <= ~(^{sense_parity, mod_data});
        end
        if (!stall && cycle_time_counter + 4'h1 == `CMAC_CNT_READY) begin
          data_ready <= access_granted;
        end
        if (cycle_last) begin
          active <= 1'b0;
          au_release <= access_granted[3];
          access_granted <= 4'h0;
          time_counter_enable <= 1'b0;
          addr_mux_select <= 4'h0;
          data_mux_select <= 4'h0;
          read_request_gate <= 1'b0;
          write_request_gate <= 1'b0;
          parity_check_enable <= 1'b0;
          cycle_time_counter <= 4'h0;
        end
      end
    end
  end

  cmac_module u_mod (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .initiate(mod_initiate),
    .power_fail(pf_s2),
    .write_mode(write_request_gate),
    .addr(addr_mux_bit[13:0]),
    .write_data(data_mux_bit),
    .sense_data(sense_data),
    .cycle_start_ff(mod_start),
    .module_busy_ff(mod_busy),
    .bit_addr_reg(mod_bit_addr),
    .lower_word_addr(),
    .upper_word_addr(),
    .plane_sense_enable(mod_sense),
    .data_reg(mod_data),
    .data_reg_strobe(mod_strobe),
    .bit_switch_enable(mod_bits)
  );

  // Registered copies keep every top output on a flop
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_start <= 1'b0;
      module_busy <= 1'b0;
      bit_addr <= 4'h0;
      plane_sense_enable <= 4'h0;
      bit_switch_enable <= 24'h000000;
    end else begin
      cycle_start <= mod_start;
      module_busy <= mod_busy;
      bit_addr <= mod_bit_addr;
      plane_sense_enable <= mod_sense;
      bit_switch_enable <= mod_bits;
    end
  end
endmodule // cmac_top

// *** sim/cmac_assertions.sv ***
module cmac_assertions (
  input wire core_clk,
  input wire rst_n,
  input wire temp_alarm,
  input wire stop_on_parity,
  input wire large_system,
  input wire [3:0] access_granted,
  input wire [3:0] data_ready,
  input wire au_release,
  input wire [3:0] cycle_time_counter,
  input wire [3:0] addr_mux_select,
  input wire [14:0] addr_mux_bit,
  input wire read_request_gate,
  input wire write_request_gate,
  input wire parity_check_enable,
  input wire module_initiate,
  input wire lower_stack_initiate,
  input wire upper_stack_initiate,
  input wire cycle_start,
  input wire module_busy,
  input wire [3:0] plane_sense_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire init_any = module_initiate | lower_stack_initiate | upper_stack_initiate;
  logic [1:0] quiet;
  // Halt inputs pass two sync flops, so only three calm samples guarantee a running counter
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) quiet <= 2'h0;
    else if (temp_alarm || stop_on_parity) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  sequence s_init_span; init_any ##2 !init_any; endsequence
  sequence s_close; (access_granted == 4'h0) && (au_release == $past(access_granted[3])); endsequence
  property p_onehot; access_granted != 4'h0 |-> $onehot(access_granted); endproperty
  a_onehot: assert property (p_onehot) else $error("grant not one-hot");
  property p_select; access_granted != 4'h0 |-> addr_mux_select == access_granted; endproperty
  a_select: assert property (p_select) else $error("select differs from grant");
  property p_rw; access_granted != 4'h0 |-> read_request_gate != write_request_gate
    && parity_check_enable == read_request_gate; endproperty
  a_rw: assert property (p_rw) else $error("read write gates wrong");
  property p_count; quiet == 2'h3 && access_granted != 4'h0 && cycle_time_counter != 4'hF
    |=> cycle_time_counter == $past(cycle_time_counter) + 4'h1; endproperty
  a_count: assert property (p_count) else $error("counter did not advance");
  property p_launch; $rose(|access_granted) && quiet == 2'h3 |-> s_init_span; endproperty
  a_launch: assert property (p_launch) else $error("initiate span wrong");
  property p_stack; lower_stack_initiate || upper_stack_initiate |-> large_system
    && upper_stack_initiate == addr_mux_bit[14] && lower_stack_initiate != addr_mux_bit[14]; endproperty
  a_stack: assert property (p_stack) else $error("wrong stack initiated");
  property p_ready; cycle_time_counter == 4'h8 && $past(cycle_time_counter) == 4'h7
    |-> data_ready == access_granted; endproperty
  a_ready: assert property (p_ready) else $error("data ready missing");
  property p_end; quiet == 2'h3 && cycle_time_counter == 4'hF && access_granted != 4'h0 |=> s_close; endproperty
  a_end: assert property (p_end) else $error("cycle end wrong");
  property p_start; cycle_start |-> $past(init_any) && !$past(module_busy) ##1 module_busy; endproperty
  a_start: assert property (p_start) else $error("cycle start wrong");
  property p_plane; plane_sense_enable != 4'h0 |-> plane_sense_enable == 4'h1 << addr_mux_bit[13:12]; endproperty
  a_plane: assert property (p_plane) else $error("wrong plane enabled");
endmodule // cmac_assertions

// *** sim/cmac_requester.sv ***
module cmac_requester (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] go,
  input wire [3:0] data_ready,
  output logic [2:0] ch_mem_request,
  output logic au_mem_request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] req;
  // A requester holds its request until its data ready pulse, then lets go
  // Rising edge keeps clear of the bench changing go on the falling edge
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) req <= 4'h0;
    else req <= (req | go) & ~data_ready;
  assign ch_mem_request = req[2:0];
  assign au_mem_request = req[3];
endmodule // cmac_requester

// *** sim/cmac_top_bench.sv ***
module cmac_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] go = 4'h0;
  logic [3:0] req_write = 4'h0;
  logic [59:0] req_addr = 60'h0;
  logic [95:0] req_wdata = 96'h0;
  logic [23:0] sense_data = 24'h0;
  logic sense_parity = 1'b0;
  logic temp_alarm = 1'b0;
  logic stop_on_parity = 1'b0;
  logic power_fail = 1'b0;
  logic large_system = 1'b1;
  wire [3:0] data_mux_select, bit_addr;
  wire [23:0] bit_switch_enable;
  wire time_counter_enable, module_initiate, lower_stack_initiate, cycle_start, module_busy;
  wire [2:0] ch_mem_request;
  wire au_mem_request;
  wire [3:0] access_granted, data_ready, cycle_time_counter;
  wire [14:0] addr_mux_bit;
  wire [23:0] data_mux_bit, read_data;
  wire au_release, read_request_gate, write_request_gate, upper_stack_initiate, parity_error;
  int mismatches = 0;
  int tests_run = 0;
  always #50 core_clk = ~core_clk;
  cmac_requester i_req (.core_clk, .rst_n, .go, .data_ready, .ch_mem_request, .au_mem_request);
  cmac_top i_dut (.core_clk, .rst_n, .ch_mem_request, .au_mem_request, .req_write, .req_addr, .req_wdata,
    .sense_data, .sense_parity, .stop_on_parity, .temp_alarm, .power_fail, .large_system,
    .access_granted, .data_ready, .au_release, .time_counter_enable, .cycle_time_counter, .addr_mux_select(),
    .data_mux_select, .addr_mux_bit, .data_mux_bit, .read_request_gate, .write_request_gate,
    .parity_check_enable(), .module_initiate, .lower_stack_initiate, .upper_stack_initiate, .parity_error,
    .read_data, .cycle_start, .module_busy, .bit_addr, .plane_sense_enable(), .bit_switch_enable);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic launch(input logic [3:0] who);
    go = who;
    cyc(1);
    go = 4'h0;
    for (int i = 0; i < 40 && access_granted === 4'h0; i++) cyc(1);
  endtask
  task automatic finish_cycle;
    for (int i = 0; i < 40 && access_granted !== 4'h0; i++) cyc(1);
  endtask
  task automatic run_one(input int k, input logic wr, input logic [14:0] a, input logic [23:0] d, input logic bad);
    logic [4:0] gates;
    req_write[k] = wr;
    req_addr[k*15+:15] = a;
    req_wdata[k*24+:24] = d;
    sense_data = ~d;
    sense_parity = bad ^ ~(^(~d));
    launch(4'h1 << k);
    chk(access_granted, 4'h1 << k);
    chk(addr_mux_bit, a);
    chk(data_mux_bit, d);
    gates = {read_request_gate, write_request_gate, module_initiate, lower_stack_initiate, upper_stack_initiate};
    chk(gates, {~wr, wr, ~large_system, large_system & ~a[14], large_system & a[14]});
    chk({time_counter_enable, data_mux_select}, {1'b1, 4'h1 << k});
    for (int i = 0; i < 20 && data_ready === 4'h0; i++) cyc(1);
    chk(data_ready, 4'h1 << k);
    chk({bit_addr, bit_switch_enable}, {a[3:0], wr ? d : ~d});
    if (!wr) chk({parity_error, read_data}, {bad, ~d});
    finish_cycle;
    chk(au_release, k == 3);
  endtask
  task automatic prio_all;
    go = 4'hF;
    for (int k = 0; k < 4; k++) begin
      launch(go);
      chk(access_granted, 4'h1 << k);
      finish_cycle;
    end
  endtask
  task automatic stall;
    logic [3:0] c;
    launch(4'h2);
    temp_alarm = 1'b1;
    cyc(4);
    c = cycle_time_counter;
    cyc(5);
    chk(cycle_time_counter, c);
    chk(time_counter_enable, 1'b0);
    temp_alarm = 1'b0;
    finish_cycle;
  endtask
  // Bad parity with the stop option set must freeze the counter until the option drops
  task automatic stop_par;
    logic [3:0] c;
    stop_on_parity = 1'b1;
    sense_parity = ~sense_parity;
    launch(4'h4);
    cyc(12);
    c = cycle_time_counter;
    cyc(3);
    chk({parity_error, time_counter_enable, data_ready, cycle_time_counter}, {1'b1, 1'b0, 4'h0, c});
    stop_on_parity = 1'b0;
    sense_parity = ~sense_parity;
    finish_cycle;
  endtask
  task automatic pfail;
    logic seen;
    seen = 1'b0;
    power_fail = 1'b1;
    launch(4'h1);
    for (int i = 0; i < 6; i++) begin
      seen |= cycle_start | module_busy;
      cyc(1);
    end
    chk(seen, 1'b0);
    power_fail = 1'b0;
    finish_cycle;
  endtask
  task automatic print_verdict;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(2);
    chk({access_granted, cycle_time_counter}, 8'h00);
    run_one(0, 1'b1, 15'h4ABC, 24'hA5A5A5, 1'b0);
    run_one(1, 1'b0, 15'h1234, 24'h0F0F01, 1'b0);
    run_one(2, 1'b0, 15'h7FFF, 24'hFFFFFF, 1'b1);
    run_one(3, 1'b1, 15'h0000, 24'h000001, 1'b0);
    run_one(3, 1'b0, 15'h2001, 24'h123456, 1'b0);
    large_system = 1'b0;
    run_one(1, 1'b1, 15'h6F0F, 24'h00F0F0, 1'b0);
    large_system = 1'b1;
    prio_all;
    stall;
    stop_par;
    pfail;
    print_verdict;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #2000000;
    mismatches++;
    print_verdict;
  end
endmodule // cmac_top_bench
bind cmac_top cmac_assertions i_chk (.core_clk, .rst_n, .temp_alarm, .stop_on_parity, .large_system,
  .access_granted, .data_ready, .au_release, .cycle_time_counter, .addr_mux_select, .addr_mux_bit,
  .read_request_gate, .write_request_gate, .parity_check_enable, .module_initiate, .lower_stack_initiate,
  .upper_stack_initiate, .cycle_start, .module_busy, .plane_sense_enable);
